/* branch_compare.sv */
/*
 * Combinational comparator for the four real compare-and-branch kinds.
 * Assumes operands arrive already in the order the instruction names them.
 */
`timescale 1ns/1ps
module branch_compare #(
    parameter int DW = 32
) (
    cmp_if.unit cmp
);
    logic ltSigned;
    logic ltUnsigned;

    assign ltSigned = $signed(cmp.opA) < $signed(cmp.opB);
    assign ltUnsigned = cmp.opA < cmp.opB;

    always_comb begin
        case (cmp.sel)
            branch_pkg::CMP_GE: cmp.taken = cmp.valid && !ltSigned;     // RULE_12
            branch_pkg::CMP_LT: cmp.taken = cmp.valid && ltSigned;      // RULE_10
            branch_pkg::CMP_GEU: cmp.taken = cmp.valid && !ltUnsigned;  // RULE_01
            branch_pkg::CMP_LTU: cmp.taken = cmp.valid && ltUnsigned;   // RULE_11
            default: cmp.taken = 1'b0;
        endcase
    end
endmodule

/* branch_pkg.sv */
/*
 * Constants and types for the compare-and-branch unit.
 * Assumes a 32-bit instruction word and byte-addressed program counter.
 */
// Functional notes
// RULE_01 - Unsigned greater-or-equal branch compares operands unsigned, taken when first >= second.
// RULE_02 - A branch not taken sets next program counter to current plus 4.
// RULE_03 - Taken target is address after branch plus offset words scaled to 14-bit bytes.
// RULE_04 - Offset field is 12-bit two's complement, sign-extended before the add.
// RULE_05 - Branch uses short-immediate format; register fields index both comparator sources.
// RULE_06 - Signed greater-than is signed less-than with operands exchanged.
// RULE_07 - Unsigned greater-than is unsigned less-than with operands exchanged.
// RULE_08 - Signed less-or-equal is signed greater-or-equal with operands exchanged.
// RULE_09 - Unsigned less-or-equal is unsigned greater-or-equal with operands exchanged.
// RULE_10 - Signed less-than compares two's complement, taken when first strictly smaller.
// RULE_11 - Unsigned less-than compares unsigned, taken when first strictly smaller.
// RULE_12 - Signed greater-or-equal compares two's complement, taken when first not smaller.
// RULE_13 - Opcode 31:26, first index 25:21, second 20:16, selector 15:12, offset 11:0.
package branch_pkg;
    localparam int OPC_MSB = 31;
    localparam int OPC_LSB = 26;
    localparam int SRCA_MSB = 25;
    localparam int SRCA_LSB = 21;
    localparam int SRCB_MSB = 20;
    localparam int SRCB_LSB = 16;
    localparam int SEL_MSB = 15;
    localparam int SEL_LSB = 12;
    localparam int OFS_MSB = 11;
    localparam int OFS_LSB = 0;
    localparam int OFS_W = 12;
    localparam int WORD_SHIFT = 2;
    localparam int BYTE_OFS_W = 14;
    localparam logic [5:0] OPC_SHORT_IMM = 6'h01;
    localparam logic [31:0] INSN_STEP = 32'h0000_0004;
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    localparam int CYCLES_TO_RESULT = 1;

    typedef enum logic [3:0] {
        CMP_GE  = 4'h9,
        CMP_LT  = 4'hA,
        CMP_GEU = 4'hD,
        CMP_LTU = 4'hE
    } cmp_sel_t;
endpackage

/* branch_unit.sv */
/*
 * Decode and execute stage for compare-and-branch instructions.
 * Assumes the register file answers reads combinationally from the index ports,
 * and that the fetch stage presents one instruction with its address per valid cycle.
 * Pseudo-branches are swapped by the assembler; the hardware sees only real forms.
 */
`timescale 1ns/1ps
module branch_unit #(
    parameter int DW = 32
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Instruction in
    input wire logic insnValid,
    input wire logic [31:0] insnWord,
    input wire logic [DW-1:0] insnPc,
    // Register file read
    output logic [4:0] firstSourceIdx,
    output logic [4:0] secondSourceIdx,
    input wire logic [DW-1:0] firstSourceData,
    input wire logic [DW-1:0] secondSourceData,
    // Result
    output logic resultValid,
    output logic branchTaken,
    output logic isBranch,
    output logic [DW-1:0] nextPc
);
    // Elaboration checks: the field layout and the datapath must agree

    // Port widths and register indexes below are fixed for a 32-bit word
    if (DW != 32) begin : g_bad_dw
        $error("branch_unit supports only a 32-bit datapath");
    end

    // Offset field bounds must match its declared width
    if (branch_pkg::OFS_MSB - branch_pkg::OFS_LSB + 1 != branch_pkg::OFS_W) begin : g_bad_ofs
        $error("branch_unit offset field bounds disagree with its width");
    end

    // Scaling by the word shift must land exactly on the byte offset width
    if (branch_pkg::OFS_W + branch_pkg::WORD_SHIFT != branch_pkg::BYTE_OFS_W) begin : g_bad_scale
        $error("branch_unit byte offset width disagrees with the scaling");
    end

    // The byte offset has to fit inside the program counter
    if (branch_pkg::BYTE_OFS_W > DW) begin : g_bad_fit
        $error("branch_unit byte offset is wider than the datapath");
    end

    // Opcode field feeds a 6-bit compare
    if (branch_pkg::OPC_MSB - branch_pkg::OPC_LSB != 5) begin : g_bad_opc
        $error("branch_unit opcode field must be 6 bits");
    end

    // Both register index ports are 5 bits
    if (branch_pkg::SRCA_MSB - branch_pkg::SRCA_LSB != 4) begin : g_bad_srca
        $error("branch_unit first index field must be 5 bits");
    end

    if (branch_pkg::SRCB_MSB - branch_pkg::SRCB_LSB != 4) begin : g_bad_srcb
        $error("branch_unit second index field must be 5 bits");
    end

    // Selector field must match the 4-bit compare kind
    if (branch_pkg::SEL_MSB - branch_pkg::SEL_LSB != 3) begin : g_bad_sel
        $error("branch_unit selector field must be 4 bits");
    end

    cmp_if #(.DW(DW)) cmp ();

    // Decoded fields
    logic [5:0] opcode;
    logic [3:0] selector;
    logic [branch_pkg::OFS_W-1:0] branchOffsetField;

    // Selector decode
    logic selGe;
    logic selLt;
    logic selGeu;
    logic selLtu;
    logic selKnown;
    logic isCmpBranch;

    // Address arithmetic
    logic [DW-1:0] fallThrough;
    logic [DW-1:0] byteOffset;
    logic [DW-1:0] target;

    // Registered result
    logic resultValid_ff;
    logic branchTaken_ff;
    logic isBranch_ff;
    logic [DW-1:0] nextPc_ff;
    logic [DW-1:0] nxt_nextPc;

    // Field split of the short-immediate format
    assign opcode = insnWord[branch_pkg::OPC_MSB:branch_pkg::OPC_LSB];              // RULE_13
    assign firstSourceIdx = insnWord[branch_pkg::SRCA_MSB:branch_pkg::SRCA_LSB];    // RULE_05
    assign secondSourceIdx = insnWord[branch_pkg::SRCB_MSB:branch_pkg::SRCB_LSB];   // RULE_05
    assign selector = insnWord[branch_pkg::SEL_MSB:branch_pkg::SEL_LSB];            // RULE_13
    assign branchOffsetField = insnWord[branch_pkg::OFS_MSB:branch_pkg::OFS_LSB];   // RULE_04

    // One flag per real compare kind; unknown codes leave all four low
    always_comb begin
        selGe = 1'b0;
        selLt = 1'b0;
        selGeu = 1'b0;
        selLtu = 1'b0;
        case (selector)
            branch_pkg::CMP_GE: begin
                selGe = 1'b1;                                                       // RULE_12
            end
            branch_pkg::CMP_LT: begin
                selLt = 1'b1;                                                       // RULE_10
            end
            branch_pkg::CMP_GEU: begin
                selGeu = 1'b1;                                                      // RULE_01
            end
            branch_pkg::CMP_LTU: begin
                selLtu = 1'b1;                                                      // RULE_11
            end
            default: begin
                selGe = 1'b0;
            end
        endcase
    end

    assign selKnown = selGe || selLt || selGeu || selLtu;

    // A wrong opcode or selector still advances the PC, but never redirects
    assign isCmpBranch = insnValid && (opcode == branch_pkg::OPC_SHORT_IMM) && selKnown;

    // Operands go in the order the fields name; swapped pseudo-forms arrive pre-swapped
    assign cmp.opA = firstSourceData;                                               // RULE_06
    assign cmp.opB = secondSourceData;                                              // RULE_07
    assign cmp.sel = branch_pkg::cmp_sel_t'(selector);                              // RULE_08
    assign cmp.valid = isCmpBranch;                                                 // RULE_09

    branch_compare #(.DW(DW)) comparator (
        .cmp(cmp)
    );

    // Word count scaled by four gives a 14-bit byte offset, then sign-extended.
    // Built bit by bit so the low zeros, the field and the sign copies are explicit.
    for (genvar bitIdx = 0; bitIdx < DW; bitIdx++) begin : g_ofs_bit
        if (bitIdx < branch_pkg::WORD_SHIFT) begin : g_low
            assign byteOffset[bitIdx] = 1'b0;                                       // RULE_03
        end else if (bitIdx < branch_pkg::BYTE_OFS_W) begin : g_field
            assign byteOffset[bitIdx] = branchOffsetField[bitIdx - branch_pkg::WORD_SHIFT];
        end else begin : g_sign
            assign byteOffset[bitIdx] = branchOffsetField[branch_pkg::OFS_W-1];    // RULE_04
        end
    end

    // Both sums wrap at the PC width, as the program counter itself does
    assign fallThrough = insnPc + DW'(branch_pkg::INSN_STEP);                       // RULE_02
    assign target = fallThrough + byteOffset;                                       // RULE_03

    always_comb begin
        if (cmp.taken) begin
            nxt_nextPc = target;                                                    // RULE_01
        end else begin
            nxt_nextPc = fallThrough;                                               // RULE_02
        end
    end

    // Result registered so the fetch stage sees a clean redirect one cycle later

    // One result strobe per accepted instruction
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            resultValid_ff <= 1'b0;
        end else begin
            resultValid_ff <= insnValid;
        end
    end

    // Marks the instructions this unit recognised as compare branches
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            isBranch_ff <= 1'b0;
        end else begin
            isBranch_ff <= isCmpBranch;                                             // RULE_05
        end
    end

    // Verdict is already gated by valid inside the comparator
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            branchTaken_ff <= 1'b0;
        end else begin
            branchTaken_ff <= cmp.taken;                                            // RULE_01
        end
    end

    // Next PC holds over idle cycles so a late reader still sees the last answer
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            nextPc_ff <= branch_pkg::PC_RESET;
        end else if (insnValid) begin
            nextPc_ff <= nxt_nextPc;
        end
    end

    assign resultValid = resultValid_ff;
    assign isBranch = isBranch_ff;
    assign branchTaken = branchTaken_ff;
    assign nextPc = nextPc_ff;
endmodule

/* branch_unit_monitor.sv */
/* Checker for branch_unit: operand indexes, compare verdicts, next PC.
   Assumes it is bound to branch_unit and sees only that module's ports. */
`timescale 1ns/1ps
module branch_unit_monitor #(parameter int DW = 32) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Instruction and operands
    input wire logic insnValid,
    input wire logic [31:0] insnWord,
    input wire logic [DW-1:0] insnPc,
    input wire logic [4:0] firstSourceIdx,
    input wire logic [4:0] secondSourceIdx,
    input wire logic [DW-1:0] firstSourceData,
    input wire logic [DW-1:0] secondSourceData,
    // Result
    input wire logic resultValid,
    input wire logic branchTaken,
    input wire logic isBranch,
    input wire logic [DW-1:0] nextPc
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    wire isCmp = insnValid && insnWord[31:26] == 6'h01;
    wire [3:0] sel = insnWord[15:12];
    wire geU = firstSourceData >= secondSourceData;
    wire ltS = $signed(firstSourceData) < $signed(secondSourceData);
    // Word offset scaled to bytes and sign-extended to the PC width
    wire [DW-1:0] ofs = {{(DW-14){insnWord[11]}}, insnWord[11:0], 2'h0};
    property p_idx; firstSourceIdx == insnWord[25:21] && secondSourceIdx == insnWord[20:16];
    endproperty
    a_idx: assert property (p_idx) else $error("bad index");
    property p_valid; insnValid |=> resultValid; endproperty
    a_valid: assert property (p_valid) else $error("no result");
    property p_geu; isCmp && sel == 4'hD |=> isBranch && branchTaken == $past(geU); endproperty
    a_geu: assert property (p_geu) else $error("bad geu");
    property p_ltu; isCmp && sel == 4'hE |=> isBranch && branchTaken == !$past(geU); endproperty
    a_ltu: assert property (p_ltu) else $error("bad ltu");
    property p_ges; isCmp && sel == 4'h9 |=> isBranch && branchTaken == !$past(ltS); endproperty
    a_ges: assert property (p_ges) else $error("bad ge");
    property p_lts; isCmp && sel == 4'hA |=> isBranch && branchTaken == $past(ltS); endproperty
    a_lts: assert property (p_lts) else $error("bad lt");
    property p_fall; insnValid ##1 !branchTaken |-> nextPc == $past(insnPc) + 4; endproperty
    a_fall: assert property (p_fall) else $error("bad fall-through");
    property p_tgt; insnValid ##1 branchTaken |-> nextPc == $past(insnPc) + 4 + $past(ofs);
    endproperty
    a_tgt: assert property (p_tgt) else $error("bad target");
    c_taken: cover property (isCmp ##1 branchTaken);
    c_fall: cover property (isCmp ##1 !branchTaken);
    c_other: cover property (insnValid && !isCmp);
endmodule
bind branch_unit branch_unit_monitor #(.DW(DW)) i_mon (.*);

/* cmp_if.sv */
/*
 * Carries the operand pair and compare selector to the comparator and its verdict back.
 * Assumes both ends run in the same clock domain.
 */
`timescale 1ns/1ps
interface cmp_if #(parameter int DW = 32);
    logic [DW-1:0] opA;
    logic [DW-1:0] opB;
    branch_pkg::cmp_sel_t sel;
    logic valid;
    logic taken;
    modport decoder (output opA, output opB, output sel, output valid, input taken);
    modport unit (input opA, input opB, input sel, input valid, output taken);
endinterface

/* unsigned_ge_branch_unit_bench.sv */
/* Self-checking bench for branch_unit with a tiny register file model.
   Assumes the monitor file is compiled with the design. */
`timescale 1ns/1ps
module unsigned_ge_branch_unit_bench;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic insnValid = 1'b0;
    logic [31:0] insnWord = 32'h0;
    logic [31:0] insnPc = 32'h0;
    logic [4:0] firstSourceIdx, secondSourceIdx;
    logic [31:0] firstSourceData, secondSourceData, nextPc;
    logic resultValid, branchTaken, isBranch;
    logic [31:0] regs [0:31];
    int numErrors = 0;
    int samplesChecked = 0;
    assign firstSourceData = regs[firstSourceIdx];
    assign secondSourceData = regs[secondSourceIdx];
    branch_unit #(.DW(32)) i_dut (.*);
    initial forever #2.5 ref_clk = ~ref_clk;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic issue(input logic [5:0] op, input logic [3:0] sel, input logic [4:0] a,
        input logic [4:0] b, input logic [11:0] imm, input logic exp);
        logic br;
        br = op == 6'h01 && sel inside {4'h9, 4'hA, 4'hD, 4'hE};
        @(posedge ref_clk);
        insnValid <= 1'b1;
        insnWord <= {op, a, b, sel, imm};
        insnPc <= 32'h0000_8000;
        @(posedge ref_clk);
        insnValid <= 1'b0;
        #1;
        check("kind", {31'h0, isBranch}, {31'h0, br});
        check("taken", {31'h0, branchTaken}, {31'h0, exp});
        check("next", nextPc, exp ? 32'h8004 + {{18{imm[11]}}, imm, 2'h0} : 32'h8004);
        check("valid", {31'h0, resultValid}, 32'h1);
        @(posedge ref_clk);
        #1;
        check("idle", {31'h0, resultValid}, 32'h0);
        check("hold", nextPc, exp ? 32'h8004 + {{18{imm[11]}}, imm, 2'h0} : 32'h8004);
    endtask
    // Registers: r1 = r2 = 5, r3 = 7, r4 = all ones (huge unsigned, -1 signed)
    task automatic t_unsigned();
        issue(6'h01, 4'hD, 5'h01, 5'h02, 12'h7FF, 1'b1);
        issue(6'h01, 4'hD, 5'h03, 5'h04, 12'h800, 1'b0);
        issue(6'h01, 4'hD, 5'h04, 5'h03, 12'hFFF, 1'b1);
        issue(6'h01, 4'hE, 5'h04, 5'h03, 12'h001, 1'b0);
        issue(6'h01, 4'hE, 5'h03, 5'h04, 12'h010, 1'b1);
    endtask
    task automatic t_signed();
        issue(6'h01, 4'h9, 5'h03, 5'h04, 12'h020, 1'b1);
        issue(6'h01, 4'h9, 5'h01, 5'h02, 12'hF00, 1'b1);
        issue(6'h01, 4'hA, 5'h04, 5'h03, 12'h003, 1'b1);
        issue(6'h01, 4'hA, 5'h02, 5'h01, 12'h004, 1'b0);
    endtask
    task automatic t_refused();
        issue(6'h02, 4'hD, 5'h01, 5'h02, 12'h004, 1'b0);
        issue(6'h01, 4'h0, 5'h01, 5'h02, 12'h004, 1'b0);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samplesChecked, numErrors);
        if (numErrors == 0 && samplesChecked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        regs[1] = 32'h5;
        regs[2] = 32'h5;
        regs[3] = 32'h7;
        regs[4] = 32'hFFFF_FFFF;
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        t_unsigned();
        t_signed();
        t_refused();
        conclude();
    end
    // About 45 cycles are needed; a hang is cut off well beyond that
    initial begin
        repeat (500) @(posedge ref_clk);
        numErrors++;
        conclude();
    end
endmodule
